/* sfcs_pkg.sv */
// constants and state types for the serial-flash configuration sequencer
// assumes a 20 MHz system clock and a free-running internal oscillator clock
`default_nettype none
package sfcs_pkg;
  // system clock rate
  localparam int CLK_MHZ = 20;
  // least low time on the reprogram input, rounded up to whole clocks
  localparam int PROG_MIN_NS = 300;
  localparam int PROG_MIN_CYC = (PROG_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CNT_W = 4;
  localparam logic [PROG_CNT_W-1:0] PROG_MIN = PROG_CNT_W'(PROG_MIN_CYC);
  // configuration memory clearing time
  localparam int CLEAR_US = 1000;
  localparam int CLEAR_CYC = CLEAR_US * CLK_MHZ;
  localparam int CLEAR_W = 16;
  // mode pattern for serial-flash loading: M2=0, M1=0, M0=1
  localparam logic [2:0] MODE_SPI = 3'h1;
  // flash read command, start address of the image
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [23:0] IMAGE_ADDR = 24'h000000;
  localparam int CMD_BITS = 32;
  // image: rate option byte, payload bytes, crc high, crc low
  localparam int PAYLOAD_BYTES = 72668;
  localparam int BYTE_CNT_W = 24;
  // crc-16, polynomial and seed; checking through the stored crc leaves zero
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  // configuration clock half periods in oscillator cycles
  localparam int HALF_W = 5;
  localparam logic [HALF_W-1:0] HALF_RATE0 = 5'h10;
  localparam logic [HALF_W-1:0] HALF_RATE1 = 5'h08;
  localparam logic [HALF_W-1:0] HALF_RATE2 = 5'h06;
  // user bus bit positions
  localparam int UB_MOSI = 0;
  localparam int UB_CLK = 1;
  localparam int UB_SEL = 2;
  localparam int UB_DRIVE = 3;

  typedef enum logic [2:0] {
    CLEARING, WAIT_INIT, LOADING, USER_MODE, CRC_FAIL, MODE_BAD, PROG_HELD
  } sfcs_ctrl_e;

  typedef enum logic [1:0] {
    L_IDLE, L_CMD, L_DATA, L_DONE
  } sfcs_link_e;
endpackage : sfcs_pkg
`default_nettype wire

/* sfcs_config_sequencer.sv */
// configuration sequencer: flags, reprogram handling and the serial-flash load
// assumes oscClk is a free-running internal oscillator unrelated to clk;
// open-drain pins are resolved outside from the *Oe outputs
`timescale 1ns/1ps
`default_nettype none

module sfcs_config_sequencer #(
  parameter int CLEAR_CYCLES = sfcs_pkg::CLEAR_CYC,
  parameter int PAYLOAD_BYTES = sfcs_pkg::PAYLOAD_BYTES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       oscClk,
  input  wire logic       reprogram_n,
  input  wire logic [2:0] modeSelect,
  input  wire logic       pullup_disable,
  input  wire logic       initIn,
  output logic            initOut,
  output logic            initOe,
  input  wire logic       doneIn,
  output logic            doneOut,
  output logic            doneOe,
  output logic            flash_select_n,
  output logic            flashSelectOe,
  output logic            config_clock_out,
  output logic            configClockOe,
  output logic            mosiOut,
  output logic            mosiOe,
  input  wire logic       dinIn,
  output logic            chainOut,
  output logic            chainOe,
  input  wire logic       userSelectN,
  input  wire logic       userClock,
  input  wire logic       userMosi,
  input  wire logic       userDrive,
  output logic            userDin,
  output logic            configured,
  output logic            crcError,
  output logic            pullupEnable
);

  localparam logic [sfcs_pkg::CLEAR_W-1:0] CLEAR_LAST = sfcs_pkg::CLEAR_W'(CLEAR_CYCLES - 1);
  localparam logic [sfcs_pkg::BYTE_CNT_W-1:0] LAST_BYTE =
    sfcs_pkg::BYTE_CNT_W'(PAYLOAD_BYTES + 2);

  // system clock domain
  logic progMeta, progSync, initMeta, initSync, doneMeta, doneSync;
  logic pullupDisMeta, pullupDisSync, dinMetaC, dinSyncC;
  logic linkDoneMeta, linkDoneSync, linkOkMeta, linkOkSync;
  logic linkDone_reg, linkOk_reg;
  logic [2:0] modeMeta, modeSync;
  logic [sfcs_pkg::PROG_CNT_W-1:0] progCnt_reg;
  logic [sfcs_pkg::CLEAR_W-1:0] clearCnt_reg;
  sfcs_pkg::sfcs_ctrl_e state_reg;
  logic runLevel_reg, hiZ_reg, userMode_reg;
  logic [3:0] userBus_reg;

  // pin inputs pass two flip-flops before use
  always_ff @(posedge clk) begin
    progMeta <= reprogram_n;
    progSync <= progMeta;
    initMeta <= initIn;
    initSync <= initMeta;
    doneMeta <= doneIn;
    doneSync <= doneMeta;
    modeMeta <= modeSelect;
    modeSync <= modeMeta;
    pullupDisMeta <= pullup_disable;
    pullupDisSync <= pullupDisMeta;
    dinMetaC <= dinIn;
    dinSyncC <= dinMetaC;
    linkDoneMeta <= linkDone_reg;
    linkDoneSync <= linkDoneMeta;
    linkOkMeta <= linkOk_reg;
    linkOkSync <= linkOkMeta;
  end

  // low-time counter on reprogram; saturates at the minimum width
  always_ff @(posedge clk) begin
    if (rst || progSync) begin
      progCnt_reg <= '0;
    end else if (progCnt_reg != sfcs_pkg::PROG_MIN) begin
      progCnt_reg <= progCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clearCnt_reg <= '0;
    end else if (state_reg == sfcs_pkg::CLEARING) begin
      if (clearCnt_reg != CLEAR_LAST) begin
        clearCnt_reg <= clearCnt_reg + 1'b1;
      end
    end else begin
      clearCnt_reg <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= sfcs_pkg::CLEARING;
    end else if (!progSync && progCnt_reg == sfcs_pkg::PROG_MIN) begin
      state_reg <= sfcs_pkg::PROG_HELD;
    end else begin
      case (state_reg)
        sfcs_pkg::PROG_HELD: begin
          if (progSync) begin
            state_reg <= sfcs_pkg::CLEARING;
          end
        end
        sfcs_pkg::CLEARING: begin
          // a short reprogram pulse only pauses the end of clearing
          if (clearCnt_reg == CLEAR_LAST && progSync) begin
            state_reg <= sfcs_pkg::WAIT_INIT;
          end
        end
        sfcs_pkg::WAIT_INIT: begin
          // outside logic may hold init low until the flash is awake
          if (initSync && progSync) begin
            if (modeSync == sfcs_pkg::MODE_SPI) begin
              state_reg <= sfcs_pkg::LOADING;
            end else begin
              state_reg <= sfcs_pkg::MODE_BAD;
            end
          end
        end
        sfcs_pkg::LOADING: begin
          if (linkDoneSync) begin
            state_reg <= linkOkSync ? sfcs_pkg::USER_MODE : sfcs_pkg::CRC_FAIL;
          end
        end
        sfcs_pkg::USER_MODE, sfcs_pkg::CRC_FAIL, sfcs_pkg::MODE_BAD: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= sfcs_pkg::CLEARING;
        end
      endcase
    end
  end

  // open-drain flags: only ever pull low
  always_ff @(posedge clk) begin
    initOut <= 1'b0;
    doneOut <= 1'b0;
    if (rst) begin
      initOe <= 1'b1;
      doneOe <= 1'b1;
    end else begin
      initOe <= state_reg == sfcs_pkg::CLEARING || state_reg == sfcs_pkg::CRC_FAIL;
      doneOe <= state_reg != sfcs_pkg::USER_MODE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      runLevel_reg <= 1'b0;
      hiZ_reg <= 1'b0;
      userMode_reg <= 1'b0;
      userBus_reg <= 4'h0;
      configured <= 1'b0;
      crcError <= 1'b0;
      pullupEnable <= 1'b0;
      userDin <= 1'b0;
    end else begin
      runLevel_reg <= state_reg == sfcs_pkg::LOADING;
      hiZ_reg <= !progSync;
      userMode_reg <= state_reg == sfcs_pkg::USER_MODE;
      userBus_reg <= {userDrive, userSelectN, userClock, userMosi};
      configured <= state_reg == sfcs_pkg::USER_MODE && doneSync;
      crcError <= state_reg == sfcs_pkg::CRC_FAIL;
      pullupEnable <= !pullupDisSync && state_reg != sfcs_pkg::USER_MODE;
      userDin <= dinSyncC;
    end
  end

  // oscillator (link) domain
  logic oRstMeta, oRst, runMeta, runSync, hizMeta, hizSync, umMeta, umSync;
  logic dinMeta, dinSync;
  logic [3:0] ubMeta, ubSync;
  sfcs_pkg::sfcs_link_e lState_reg;
  logic [sfcs_pkg::HALF_W-1:0] halfPer_reg, divCnt_reg;
  logic sclk_reg, sel_reg, mosi_reg, lastBit_reg, chain_reg;
  logic [31:0] shift_reg;
  logic [4:0] bitCnt_reg;
  logic [6:0] rx_reg;
  logic [sfcs_pkg::BYTE_CNT_W-1:0] byteCnt_reg;
  logic [15:0] crc_reg, crcNext;
  logic [7:0] rxByte;
  logic tick;

  // user bits cross as independent levels; user logic must hold them steady
  always_ff @(posedge oscClk) begin
    oRstMeta <= rst;
    oRst <= oRstMeta;
    runMeta <= runLevel_reg;
    runSync <= runMeta;
    hizMeta <= hiZ_reg;
    hizSync <= hizMeta;
    umMeta <= userMode_reg;
    umSync <= umMeta;
    ubMeta <= userBus_reg;
    ubSync <= ubMeta;
    dinMeta <= dinIn;
    dinSync <= dinMeta;
  end

  assign tick = divCnt_reg == halfPer_reg - 1'b1;
  assign rxByte = {rx_reg, dinSync};
  assign crcNext = {crc_reg[14:0], 1'b0} ^ ((crc_reg[15] ^ dinSync) ? sfcs_pkg::CRC_POLY : 16'h0000);

  always_ff @(posedge oscClk) begin
    if (oRst || lState_reg == sfcs_pkg::L_IDLE || tick) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= divCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge oscClk) begin
    if (oRst) begin
      lState_reg <= sfcs_pkg::L_IDLE;
      halfPer_reg <= sfcs_pkg::HALF_RATE0;
      sclk_reg <= 1'b0;
      sel_reg <= 1'b1;
      mosi_reg <= 1'b0;
      lastBit_reg <= 1'b0;
      chain_reg <= 1'b0;
      shift_reg <= '0;
      bitCnt_reg <= '0;
      rx_reg <= '0;
      byteCnt_reg <= '0;
      crc_reg <= sfcs_pkg::CRC_SEED;
      linkDone_reg <= 1'b0;
      linkOk_reg <= 1'b0;
    end else if (!runSync && lState_reg != sfcs_pkg::L_IDLE) begin
      lState_reg <= sfcs_pkg::L_IDLE; // abort on restart
      sclk_reg <= 1'b0;
      sel_reg <= 1'b1;
      linkDone_reg <= 1'b0;
      linkOk_reg <= 1'b0;
    end else begin
      case (lState_reg)
        sfcs_pkg::L_IDLE: begin
          if (runSync) begin
            lState_reg <= sfcs_pkg::L_CMD;
            sel_reg <= 1'b0;
            halfPer_reg <= sfcs_pkg::HALF_RATE0;
            shift_reg <= {sfcs_pkg::CMD_READ, sfcs_pkg::IMAGE_ADDR};
            mosi_reg <= sfcs_pkg::CMD_READ[7];
            bitCnt_reg <= '0;
            byteCnt_reg <= '0;
            crc_reg <= sfcs_pkg::CRC_SEED;
          end
        end
        sfcs_pkg::L_CMD: begin
          if (tick) begin
            sclk_reg <= !sclk_reg;
            if (!sclk_reg) begin
              bitCnt_reg <= bitCnt_reg + 1'b1;
            end else if (bitCnt_reg == '0) begin
              lState_reg <= sfcs_pkg::L_DATA; // all command bits sent
            end else begin
              shift_reg <= {shift_reg[30:0], 1'b0};
              mosi_reg <= shift_reg[30];
            end
          end
        end
        sfcs_pkg::L_DATA: begin
          if (tick) begin
            sclk_reg <= !sclk_reg;
            if (!sclk_reg) begin
              rx_reg <= rxByte[6:0];
              lastBit_reg <= dinSync;
              bitCnt_reg <= bitCnt_reg + 1'b1;
              if (byteCnt_reg != '0) begin
                crc_reg <= crcNext;
              end
              if (bitCnt_reg[2:0] == 3'h7) begin
                byteCnt_reg <= byteCnt_reg + 1'b1;
                if (byteCnt_reg == '0) begin
                  case (rxByte[1:0])
                    2'h0: halfPer_reg <= sfcs_pkg::HALF_RATE0;
                    2'h1: halfPer_reg <= sfcs_pkg::HALF_RATE1;
                    default: halfPer_reg <= sfcs_pkg::HALF_RATE2;
                  endcase
                end
                if (byteCnt_reg == LAST_BYTE) begin
                  lState_reg <= sfcs_pkg::L_DONE;
                  linkOk_reg <= crcNext == 16'h0000;
                  sclk_reg <= 1'b0;
                end
              end
            end else begin
              chain_reg <= lastBit_reg;
            end
          end
        end
        sfcs_pkg::L_DONE: begin
          sel_reg <= 1'b1;
          linkDone_reg <= 1'b1; // set after the result is stable
        end
        default: begin
          lState_reg <= sfcs_pkg::L_IDLE;
        end
      endcase
    end
  end

  // pin stage: configuration sequence or user logic, tri-stated on reprogram
  always_ff @(posedge oscClk) begin
    if (oRst) begin
      flash_select_n <= 1'b1;
      config_clock_out <= 1'b0;
      mosiOut <= 1'b0;
      chainOut <= 1'b0;
      flashSelectOe <= 1'b0;
      configClockOe <= 1'b0;
      mosiOe <= 1'b0;
      chainOe <= 1'b0;
    end else begin
      flash_select_n <= umSync ? ubSync[sfcs_pkg::UB_SEL] : sel_reg;
      config_clock_out <= umSync ? ubSync[sfcs_pkg::UB_CLK] : sclk_reg;
      mosiOut <= umSync ? ubSync[sfcs_pkg::UB_MOSI] : mosi_reg;
      chainOut <= chain_reg;
      flashSelectOe <= !hizSync && (!umSync || ubSync[sfcs_pkg::UB_DRIVE]);
      configClockOe <= !hizSync && (!umSync || ubSync[sfcs_pkg::UB_DRIVE]);
      mosiOe <= !hizSync && (!umSync || ubSync[sfcs_pkg::UB_DRIVE]);
      chainOe <= !hizSync;
    end
  end

endmodule : sfcs_config_sequencer

`default_nettype wire

/* sfcs_props.sv */
// pin-level checks for the configuration sequencer
// assumes the open-drain wires are resolved outside the design
`timescale 1ns/1ps
`default_nettype none
module sfcs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic oscClk,
  input wire logic reprogram_n,
  input wire logic initIn,
  input wire logic initOe,
  input wire logic doneIn,
  input wire logic doneOe,
  input wire logic flash_select_n,
  input wire logic flashSelectOe,
  input wire logic config_clock_out,
  input wire logic configClockOe,
  input wire logic mosiOe,
  input wire logic chainOe,
  input wire logic configured,
  input wire logic crcError
);
  // flag, reprogram and init checks run on clk, load and clock-idle checks on the oscillator that launches them
  a_init_clear_low: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> initOe [*8])
    else $error("init released too early");
  a_crc_init_low: assert property (@(posedge clk) disable iff (rst)
    crcError |-> initOe && !configured)
    else $error("crc failure without init low");
  a_done_when_ok: assert property (@(posedge clk) disable iff (rst)
    configured |-> !crcError && $past(doneIn))
    else $error("configured while done low");
  a_held_done_low: assert property (@(posedge clk) disable iff (rst)
    !reprogram_n [*8] ##1 !reprogram_n [*4] |-> doneOe)
    else $error("done released while reprogram held");
  a_prog_hi_z: assert property (@(posedge clk) disable iff (rst)
    !reprogram_n [*8] ##1 !reprogram_n [*4] |-> !(flashSelectOe || mosiOe || configClockOe))
    else $error("flash pins driven while reprogram held");
  a_wait_init_high: assert property (@(posedge clk) disable iff (rst)
    !initIn [*4] |-> flash_select_n || !flashSelectOe)
    else $error("flash selected while init low");
  a_load_drives: assert property (@(posedge oscClk) disable iff (rst)
    (!flash_select_n && flashSelectOe && !configured) [*4]
    |-> chainOe && mosiOe && configClockOe)
    else $error("pin not driven during load");
  a_sclk_idle_low: assert property (@(posedge oscClk) disable iff (rst)
    (flash_select_n && flashSelectOe && !configured) [*4] |-> !config_clock_out)
    else $error("clock not idle low outside frame");
endmodule : sfcs_props
bind sfcs_config_sequencer sfcs_props sfcs_props_inst (.clk(clk), .rst(rst), .oscClk(oscClk),
  .reprogram_n(reprogram_n), .initIn(initIn), .initOe(initOe), .doneIn(doneIn),
  .doneOe(doneOe), .flash_select_n(flash_select_n), .flashSelectOe(flashSelectOe),
  .config_clock_out(config_clock_out), .configClockOe(configClockOe),
  .mosiOe(mosiOe), .chainOe(chainOe), .configured(configured), .crcError(crcError));
`default_nettype wire

/* sfcs_flash_model.sv */
// serial flash model: takes a 32-bit read command, then streams the image
// assumes spi mode zero and a 56-bit image (rate, 4 payload, crc)
`timescale 1ns/1ps
`default_nettype none
module sfcs_flash_model (
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        mosi,
  input  wire logic [55:0] image,
  output logic             dout,
  output logic [31:0]      cmdWord
);
  int bitCnt = 0;
  initial dout = 1'b0;
  always @(posedge sclk or posedge csN) begin
    if (csN) bitCnt <= 0;
    else begin
      if (bitCnt < 32) cmdWord <= {cmdWord[30:0], mosi};
      bitCnt <= bitCnt + 1;
    end
  end
  // undriven output toggles so a stale bit never reads as valid
  always @(negedge sclk or posedge csN) begin
    if (csN || bitCnt < 32 || bitCnt >= 88) dout <= ~dout;
    else dout <= image[87 - bitCnt];
  end
endmodule : sfcs_flash_model
`default_nettype wire

/* spi_flash_config_sequencer_bench.sv */
// bench: three loads over rate codes 0, 1 and 2, a crc failure, user mode, bad mode
// assumes pull-ups on init, done and select, pull-down on the clock pin
`timescale 1ns/1ps
`default_nettype none
module spi_flash_config_sequencer_bench;
  logic clk, rst, oscClk, reprogram_n, pullup_disable, extHold;
  logic [2:0] modeSelect;
  logic userSelectN, userClock, userMosi, userDrive;
  logic initOut, initOe, doneOut, doneOe, flash_select_n, flashSelectOe;
  logic config_clock_out, configClockOe, mosiOut, mosiOe, chainOut, chainOe;
  logic userDin, configured, crcError, pullupEnable, dout;
  logic [55:0] image;
  logic [31:0] cmdWord, seed;
  int err_count = 0, tests_run = 0, cycles = 0, frames = 0, f0;
  wire initIn = ~(initOe | extHold);
  wire doneIn = ~doneOe;
  wire csN = flashSelectOe ? flash_select_n : 1'b1;
  wire sclk = configClockOe & config_clock_out;
  sfcs_config_sequencer #(.CLEAR_CYCLES(40), .PAYLOAD_BYTES(4)) sfcs_config_sequencer_inst (
    .clk(clk), .rst(rst), .oscClk(oscClk), .reprogram_n(reprogram_n),
    .modeSelect(modeSelect), .pullup_disable(pullup_disable), .initIn(initIn),
    .initOut(initOut), .initOe(initOe), .doneIn(doneIn), .doneOut(doneOut),
    .doneOe(doneOe), .flash_select_n(flash_select_n), .flashSelectOe(flashSelectOe),
    .config_clock_out(config_clock_out), .configClockOe(configClockOe),
    .mosiOut(mosiOut), .mosiOe(mosiOe), .dinIn(dout), .chainOut(chainOut),
    .chainOe(chainOe), .userSelectN(userSelectN), .userClock(userClock),
    .userMosi(userMosi), .userDrive(userDrive), .userDin(userDin),
    .configured(configured), .crcError(crcError), .pullupEnable(pullupEnable));
  sfcs_flash_model sfcs_flash_model_inst (.sclk(sclk), .csN(csN), .mosi(mosiOut),
    .image(image), .dout(dout), .cmdWord(cmdWord));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] crc16(input logic [31:0] p);
    logic [15:0] c;
    c = sfcs_pkg::CRC_SEED;
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ p[i]) ? sfcs_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction : crc16
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic cmp(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %b expected %b", $time, got, exp);
    end
  endtask : cmp
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // link clock free running, phase unrelated to clk
  initial begin
    oscClk = 1'b0;
    #17;
    forever #62.5 oscClk = ~oscClk;
  end
  always @(negedge csN) frames++;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    seed = 32'h9b009db4;
    {rst, reprogram_n, extHold, modeSelect, pullup_disable} = {3'b111, 3'h1, seed[0]};
    {userSelectN, userClock, userMosi, userDrive, image} = '0;
    // five cycles span two oscillator rises, enough for the link reset
    tick(5);
    rst <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      image = {6'h00, r[1:0], seed, crc16(seed) ^ {15'h0000, r == 1}};
      tick(1);
      reprogram_n <= 1'b0;
      extHold <= 1'b1;
      tick(20); #1;
      cmp(flashSelectOe | mosiOe | configClockOe, 1'b0);
      cmp(doneOe, 1'b1);
      tick(1);
      reprogram_n <= 1'b1;
      tick(200); #1;
      cmp(initOe, 1'b0);
      cmp(csN, 1'b1);
      tick(1);
      extHold <= 1'b0;
      while (configured !== 1'b1 && crcError !== 1'b1) tick(1);
      tick(40); #1;
      cmp(crcError, r == 1);
      cmp(initIn, r != 1);
      cmp(doneIn, r != 1);
      cmp(configured, r != 1);
      cmp(cmdWord === {sfcs_pkg::CMD_READ, sfcs_pkg::IMAGE_ADDR}, 1'b1);
      cmp(csN, 1'b1);
      cmp(pullupEnable, r == 1 && !pullup_disable);
      cmp(chainOut, image[1]);
      cmp(initOut | doneOut, 1'b0);
    end
    tick(1);
    reprogram_n <= 1'b0;
    tick(3);
    reprogram_n <= 1'b1;
    tick(40); #1;
    cmp(configured, 1'b1);
    repeat (4) begin
      seed = lfsr(seed);
      tick(1);
      userDrive <= 1'b1;
      {userSelectN, userClock, userMosi} <= seed[2:0];
      tick(20); #1;
      cmp({flash_select_n, config_clock_out, mosiOut} === seed[2:0], 1'b1);
      cmp(flashSelectOe & configClockOe & mosiOe, 1'b1);
      cmp(userDin, dout);
    end
    tick(1);
    {userDrive, userSelectN, reprogram_n, modeSelect} <= {3'b010, 1'b1, seed[1:0]};
    f0 = frames;
    tick(20);
    reprogram_n <= 1'b1;
    tick(2000); #1;
    cmp(configured, 1'b0);
    cmp(frames == f0, 1'b1);
    end_sim();
  end
endmodule : spi_flash_config_sequencer_bench
`default_nettype wire
